// ### rtl/stat_counter_read.sv
// Purpose: indirect read path for the switch statistics counters
// Assumes: management port decodes transactions into one-cycle strobes
// Notes:   counter storage itself lives outside; this block fetches and clears
//          the host polls read_busy before collecting the four data bytes;
//          reading a data byte has no side effect on the counters
//
// What this block does
// - per-port read: control gets select code, then address write starts read.
// - first data byte holds overflow, valid, value bits 29-24; rest MSB first.
// - dropped read: control code 0x1D, address write starts; value in last bytes.
// - per-port counter is cleared by the read that fetches it.
// - dropped counters are never cleared and carry no flags.
// - ports at 0x00, 0x20, 0x40 with 32 slots; dropped at 0x100 to 0x105.
`timescale 1ns/100ps
module stat_counter_read
    import stat_read_pkg::*;
#(
    parameter int ADDR_WIDTH = COUNTER_ADDR_WIDTH
)
(
    input  wire logic                    ref_clk,
    input  wire logic                    reset_n,
    // register access from the management port
    input  wire logic [7:0]              reg_addr,
    input  wire logic [7:0]              reg_wdata,
    input  wire logic                    reg_write,
    input  wire logic                    reg_read,
    output logic      [7:0]              reg_rdata,
    output logic                         reg_rdata_valid,
    // counter store side
    output logic                         counter_req,
    output logic      [ADDR_WIDTH-1:0]   counter_addr,
    output logic                         counter_clear,
    input  wire logic                    counter_ack,
    input  wire logic [RESULT_WIDTH-1:0] counter_rdata,
    // status
    output logic                         read_busy,
    output logic                         address_unmapped
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // the address byte plus one select bit fixes the width; nothing else fits
    generate
        if (ADDR_WIDTH != COUNTER_ADDR_WIDTH) begin : g_bad_width
            $error("stat_counter_read: ADDR_WIDTH must be 9");
        end
    endgenerate

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [7:0]              indirect_control;
    logic [7:0]              indirect_address_low;
    logic [7:0]              data_byte3;
    logic [7:0]              data_byte2;
    logic [7:0]              data_byte1;
    logic [7:0]              data_byte0;
    read_state_type          state;
    logic                    fetch_dropped;
    logic                    start_read;
    logic [ADDR_WIDTH-1:0]   next_counter_addr;
    logic [RESULT_WIDTH-1:0] shaped_word;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // true when an address lies past the last counter of its half of the map
    function automatic logic beyond_map(input logic [ADDR_WIDTH-1:0] address);
        if (is_dropped_address(address)) begin
            return address > DROPPED_LAST;
        end
        return address > PER_PORT_LAST;
    endfunction : beyond_map

    // a read starts only when the select field names the statistics space;
    // an address write during a fetch is stored but cannot start a second one
    assign next_counter_addr = {indirect_control[ADDRESS_HIGH_BIT], reg_wdata};
    assign start_read = reg_write && (reg_addr == OFFSET_INDIRECT_ADDRESS_LOW)
                        && (indirect_control[SELECT_MSB:SELECT_LSB] == STAT_READ_SELECT)
                        && (state == IDLE);

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    // the control byte persists, so another address write repeats the
    // same kind of read without rewriting the select code
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            indirect_control <= CONTROL_RESET;
        end else if (reg_write && reg_addr == OFFSET_INDIRECT_CONTROL) begin
            indirect_control <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            indirect_address_low <= ADDRESS_LOW_RESET;
        end else if (reg_write && reg_addr == OFFSET_INDIRECT_ADDRESS_LOW) begin
            indirect_address_low <= reg_wdata;
        end
    end

    // ------------------------------------------------------------
    // fetch sequencer
    // ------------------------------------------------------------
    // the clear travels with the request so the store can zero the counter
    // in the same cycle it hands out the value; no increment slips between
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state         <= IDLE;
            counter_req   <= 1'b0;
            counter_clear <= 1'b0;
        end else begin
            case (state)
                IDLE: begin
                    if (start_read) begin
                        state         <= FETCH;
                        counter_req   <= 1'b1;
                        counter_clear <= !is_dropped_address(next_counter_addr);
                    end
                end
                FETCH: begin
                    if (counter_ack) begin
                        state         <= HOLD;
                        counter_req   <= 1'b0;
                        counter_clear <= 1'b0;
                    end
                end
                // one spare cycle lets the data bytes settle before busy drops
                HOLD: begin
                    state <= IDLE;
                end
                default: begin
                    state <= IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // request attributes, captured once per trigger
    // ------------------------------------------------------------
    // an out-of-range address still goes to the store; the flag only tells
    // the host that the value it collects has no counter behind it
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            counter_addr     <= '0;
            fetch_dropped    <= 1'b0;
            address_unmapped <= 1'b0;
        end else if (start_read) begin
            counter_addr     <= next_counter_addr;
            fetch_dropped    <= is_dropped_address(next_counter_addr);
            address_unmapped <= beyond_map(next_counter_addr);
        end
    end

    assign read_busy = (state != IDLE);

    // ------------------------------------------------------------
    // result capture
    // ------------------------------------------------------------
    stat_result_format u_format (
        .dropped     (fetch_dropped),
        .raw_word    (counter_rdata),
        .shaped_word (shaped_word)
    );

    // bytes stand until the next fetch completes, so stale values are
    // seen if the host collects them while the sequencer is still in FETCH
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            data_byte3 <= DATA_RESET;
            data_byte2 <= DATA_RESET;
            data_byte1 <= DATA_RESET;
            data_byte0 <= DATA_RESET;
        end else if (state == FETCH && counter_ack) begin
            data_byte3 <= shaped_word[31:24];
            data_byte2 <= shaped_word[23:16];
            data_byte1 <= shaped_word[15:8];
            data_byte0 <= shaped_word[7:0];
        end
    end

    // ------------------------------------------------------------
    // register read path
    // ------------------------------------------------------------
    // reads have no side effect; a rejected offset simply returns zero
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            reg_rdata_valid <= 1'b0;
        end else begin
            reg_rdata_valid <= reg_read;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            reg_rdata <= UNMAPPED_READ_VALUE;
        end else begin
            if (reg_read) begin
                if (reg_addr == OFFSET_INDIRECT_CONTROL) begin
                    reg_rdata <= indirect_control;
                end else if (reg_addr == OFFSET_INDIRECT_ADDRESS_LOW) begin
                    reg_rdata <= indirect_address_low;
                end else if (reg_addr == OFFSET_INDIRECT_DATA_BYTE3) begin
                    reg_rdata <= data_byte3;
                end else if (reg_addr == OFFSET_INDIRECT_DATA_BYTE2) begin
                    reg_rdata <= data_byte2;
                end else if (reg_addr == OFFSET_INDIRECT_DATA_BYTE1) begin
                    reg_rdata <= data_byte1;
                end else if (reg_addr == OFFSET_INDIRECT_DATA_BYTE0) begin
                    reg_rdata <= data_byte0;
                end else begin
                    reg_rdata <= UNMAPPED_READ_VALUE;
                end
            end
        end
    end

endmodule : stat_counter_read

// ### rtl/stat_read_pkg.sv
// Purpose: shared constants for the statistics counter indirect read block
// Assumes: 8-bit register space reached through the management port
// Notes:   offsets, select codes and field positions live here only
package stat_read_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFFSET_INDIRECT_CONTROL     = 8'h79;
    localparam logic [7:0] OFFSET_INDIRECT_ADDRESS_LOW = 8'h7A;
    localparam logic [7:0] OFFSET_INDIRECT_DATA_BYTE3  = 8'h80;
    localparam logic [7:0] OFFSET_INDIRECT_DATA_BYTE2  = 8'h81;
    localparam logic [7:0] OFFSET_INDIRECT_DATA_BYTE1  = 8'h82;
    localparam logic [7:0] OFFSET_INDIRECT_DATA_BYTE0  = 8'h83;

    // ------------------------------------------------------------
    // control register layout and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CONTROL_RESET          = 8'h00;
    localparam logic [7:0] ADDRESS_LOW_RESET      = 8'h00;
    localparam logic [7:0] DATA_RESET             = 8'h00;
    localparam logic [7:0] UNMAPPED_READ_VALUE    = 8'h00;
    localparam int         SELECT_LSB             = 1;
    localparam int         SELECT_MSB             = 7;
    localparam int         ADDRESS_HIGH_BIT       = 0;
    // upper seven bits of the per-port (0x1C) and dropped (0x1D) codes
    localparam logic [6:0] STAT_READ_SELECT       = 7'h0E;
    localparam logic [7:0] PER_PORT_SELECT_CODE   = 8'h1C;
    localparam logic [7:0] DROPPED_SELECT_CODE    = 8'h1D;

    // ------------------------------------------------------------
    // counter address map
    // ------------------------------------------------------------
    localparam int         COUNTER_ADDR_WIDTH     = 9;
    localparam logic [8:0] PORT_STRIDE            = 9'h020;
    localparam logic [8:0] FIRST_PORT_BASE        = 9'h000;
    localparam logic [8:0] SECOND_PORT_BASE       = 9'h020;
    localparam logic [8:0] THIRD_PORT_BASE        = 9'h040;
    localparam logic [8:0] PER_PORT_LAST          = 9'h05F;
    localparam logic [8:0] DROPPED_FIRST          = 9'h100;
    localparam logic [8:0] DROPPED_LAST           = 9'h105;
    localparam int         DROPPED_FLAG_BIT       = 8;

    // ------------------------------------------------------------
    // result word layout
    // ------------------------------------------------------------
    localparam int         OVERFLOW_BIT           = 31;
    localparam int         VALID_BIT              = 30;
    localparam int         PER_PORT_VALUE_WIDTH   = 30;
    localparam int         DROPPED_VALUE_WIDTH    = 16;
    localparam int         RESULT_WIDTH           = 32;

    // ------------------------------------------------------------
    // host service interval (host side obligation)
    // ------------------------------------------------------------
    localparam int         HOST_SERVICE_SECONDS   = 30;

    typedef enum logic [1:0] {
        IDLE,
        FETCH,
        HOLD
    } read_state_type;

    // dropped-packet counters sit in the upper half of the address space
    function automatic logic is_dropped_address(input logic [8:0] address);
        return address[DROPPED_FLAG_BIT];
    endfunction : is_dropped_address

endpackage : stat_read_pkg

// ### rtl/stat_result_format.sv
// Purpose: shapes a raw counter word into the four data register bytes
// Assumes: raw word carries overflow and valid flags in its top bits
// Notes:   purely combinational, the caller registers the result
`timescale 1ns/100ps
module stat_result_format
    import stat_read_pkg::*;
(
    input  wire logic                    dropped,
    input  wire logic [RESULT_WIDTH-1:0] raw_word,
    output logic      [RESULT_WIDTH-1:0] shaped_word
);

    // ------------------------------------------------------------
    // flag and value masking
    // ------------------------------------------------------------
    always_comb begin
        shaped_word = '0;
        if (dropped) begin
            // no flags and only the low half for dropped counters
            shaped_word[DROPPED_VALUE_WIDTH-1:0] = raw_word[DROPPED_VALUE_WIDTH-1:0];
        end else begin
            shaped_word[OVERFLOW_BIT]               = raw_word[OVERFLOW_BIT];
            shaped_word[VALID_BIT]                  = raw_word[VALID_BIT];
            shaped_word[PER_PORT_VALUE_WIDTH-1:0]   = raw_word[PER_PORT_VALUE_WIDTH-1:0];
        end
    end

endmodule : stat_result_format

// ### tb/stat_store_model.sv
// Purpose: behavioural counter store facing the statistics read block
// Assumes: one fetch at a time, ack_delay set by the bench
// Notes:   words are preloaded by the bench through mem
`timescale 1ns/100ps
module stat_store_model (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        counter_req,
    input  wire logic [8:0]  counter_addr,
    input  wire logic        counter_clear,
    input  wire logic [3:0]  ack_delay,
    output logic             counter_ack,
    output logic      [31:0] counter_rdata
);
    logic [31:0] mem [0:511];
    logic [3:0]  waited;
    // a nonzero ack_delay makes the store stall the fetch
    always @(posedge ref_clk) begin
        if (!reset_n || !counter_req || counter_ack) waited <= 4'h0;
        else waited <= waited + 4'h1;
    end
    assign counter_ack = counter_req && (waited == ack_delay);
    always @(posedge ref_clk) begin
        if (reset_n && counter_ack && counter_clear) mem[counter_addr] <= 32'h0;
    end
    // outside the ack the word is junk, never the good value
    assign counter_rdata = counter_ack ? mem[counter_addr] : ~mem[counter_addr];
endmodule : stat_store_model

// ### tb/stat_read_chk.sv
// Purpose: port-level checks of the statistics read block
// Assumes: sees only the top module ports
// Notes:   attached by bind below
`timescale 1ns/100ps
module stat_read_chk
    import stat_read_pkg::*;
#(
    parameter int ADDR_WIDTH = COUNTER_ADDR_WIDTH
)
(
    input wire logic                    ref_clk,
    input wire logic                    reset_n,
    input wire logic [7:0]              reg_addr,
    input wire logic [7:0]              reg_wdata,
    input wire logic                    reg_write,
    input wire logic                    reg_read,
    input wire logic [7:0]              reg_rdata,
    input wire logic                    reg_rdata_valid,
    input wire logic                    counter_req,
    input wire logic [ADDR_WIDTH-1:0]   counter_addr,
    input wire logic                    counter_clear,
    input wire logic                    counter_ack,
    input wire logic [RESULT_WIDTH-1:0] counter_rdata,
    input wire logic                    read_busy,
    input wire logic                    address_unmapped
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    trigger_start_a: assert property ($rose(counter_req) |-> $past(reg_write) &&
        $past(reg_addr) == OFFSET_INDIRECT_ADDRESS_LOW && counter_addr[7:0] == $past(reg_wdata)) else $error("bad trigger");
    req_hold_a: assert property (counter_req && !counter_ack |=> counter_req && $stable(counter_addr)) else $error("req moved");
    ack_done_a: assert property (counter_req && counter_ack |=> !counter_req && read_busy ##1 !read_busy) else $error("bad end");
    busy_cover_a: assert property (counter_req |-> read_busy) else $error("req without busy");
    port_clear_a: assert property (counter_req && !counter_addr[8] |-> counter_clear) else $error("no clear");
    drop_keep_a: assert property (counter_req && counter_addr[8] |-> !counter_clear) else $error("dropped cleared");
    range_flag_a: assert property ($rose(counter_req) |->
        address_unmapped == (counter_addr > (counter_addr[8] ? 9'h105 : 9'h05F))) else $error("bad unmapped flag");
    read_answer_a: assert property (reg_read |=> reg_rdata_valid) else $error("no read answer");
    answer_cause_a: assert property (reg_rdata_valid |-> $past(reg_read)) else $error("stray read answer");
endmodule : stat_read_chk
bind stat_counter_read stat_read_chk #(.ADDR_WIDTH(ADDR_WIDTH)) i_stat_read_chk (.ref_clk, .reset_n, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata, .reg_rdata_valid, .counter_req, .counter_addr, .counter_clear,
    .counter_ack, .counter_rdata, .read_busy, .address_unmapped);

// ### tb/tb_top.sv
// Purpose: register-level tests of the statistics read block
// Assumes: strobes driven 1 ns after the rising edge
// Notes:   expected words are planted in the store model
`timescale 1ns/100ps
module tb_top;
    import stat_read_pkg::*;
    logic        ref_clk, reset_n, reg_write, reg_read, reg_rdata_valid;
    logic        counter_req, counter_clear, counter_ack, read_busy, address_unmapped;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, b;
    logic [8:0]  counter_addr;
    logic [31:0] counter_rdata;
    logic [3:0]  ack_delay;
    int          fails, num_checks;
    stat_counter_read #(.ADDR_WIDTH(9)) i_stat_counter_read (.ref_clk, .reset_n, .reg_addr, .reg_wdata,
        .reg_write, .reg_read, .reg_rdata, .reg_rdata_valid, .counter_req, .counter_addr, .counter_clear,
        .counter_ack, .counter_rdata, .read_busy, .address_unmapped);
    stat_store_model i_stat_store_model (.ref_clk, .reset_n, .counter_req, .counter_addr, .counter_clear,
        .ack_delay, .counter_ack, .counter_rdata);
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // --------------------------------------------------------
    // access tasks: one strobe cycle, then one idle cycle
    // --------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(posedge ref_clk);
        #1 reg_write = 1'b0;
        @(posedge ref_clk);
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr = a;
        reg_read = 1'b1;
        @(posedge ref_clk);
        #1 reg_read = 1'b0;
        chk(32'(reg_rdata_valid), 32'h1);
        d = reg_rdata;
        @(posedge ref_clk);
        #1;
    endtask : rd
    task automatic fetch(input logic [7:0] sel, input logic [7:0] a, input logic [31:0] exp);
        logic [7:0] d;
        int n;
        n = 0;
        wr(OFFSET_INDIRECT_CONTROL, sel);
        wr(OFFSET_INDIRECT_ADDRESS_LOW, a);
        while (read_busy !== 1'b0 && n < 40) begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk(32'(n < 40), 32'h1);
        for (int i = 0; i < 4; i++) begin
            rd(OFFSET_INDIRECT_DATA_BYTE3 + 8'(i), d);
            chk(32'(d), 32'(exp[31-8*i -: 8]));
        end
    endtask : fetch
    task automatic tally_and_finish();
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    initial begin
        #500000;
        fails++;
        tally_and_finish();
    end
    // --------------------------------------------------------
    // test sequence
    // --------------------------------------------------------
    initial begin
        {reset_n, reg_write, reg_read, reg_addr, reg_wdata, ack_delay} = '0;
        repeat (12) @(posedge ref_clk);
        #1 reset_n = 1'b1;
        for (int i = 0; i < 6; i++) begin
            rd(i < 2 ? 8'(8'h79 + i) : 8'(8'h7E + i), b);
            chk(32'(b), 32'(DATA_RESET));
        end
        i_stat_store_model.mem[9'h00E] = 32'hC123_4567;
        fetch(PER_PORT_SELECT_CODE, 8'h0E, 32'hC123_4567);
        rd(OFFSET_INDIRECT_CONTROL, b);
        chk(32'(b), 32'h1C);
        fetch(PER_PORT_SELECT_CODE, 8'h0E, 32'h0);
        chk(32'(address_unmapped), 32'h0);
        for (int p = 0; p < 3; p++) begin
            ack_delay = 4'(3 * p);
            i_stat_store_model.mem[14 + 32 * p] = 32'h4000_005A + 32'(p << 8);
            fetch(PER_PORT_SELECT_CODE, 8'(14 + 32 * p), 32'h4000_005A + 32'(p << 8));
        end
        // a second address write during a slow fetch is stored, not obeyed
        wr(OFFSET_INDIRECT_ADDRESS_LOW, 8'h0E);
        wr(OFFSET_INDIRECT_ADDRESS_LOW, 8'h2E);
        chk(32'(read_busy), 32'h1);
        repeat (8) @(posedge ref_clk);
        #1 chk(32'(read_busy), 32'h0);
        rd(OFFSET_INDIRECT_ADDRESS_LOW, b);
        chk(32'(b), 32'h2E);
        for (int k = 0; k < 6; k++) begin // each counter revisited well inside the service interval
            i_stat_store_model.mem[256 + k] = 32'hFFFF_1200 + 32'(k);
            repeat (2) fetch(DROPPED_SELECT_CODE, 8'(k), 32'h1200 + 32'(k));
        end
        i_stat_store_model.mem[9'h060] = 32'h0;
        fetch(PER_PORT_SELECT_CODE, 8'h60, 32'h0);
        chk(32'(address_unmapped), 32'h1);
        i_stat_store_model.mem[9'h106] = 32'hC000_ABCD;
        fetch(DROPPED_SELECT_CODE, 8'h06, 32'h0000_ABCD);
        chk(32'(address_unmapped), 32'h1);
        wr(OFFSET_INDIRECT_CONTROL, 8'h00);
        wr(OFFSET_INDIRECT_ADDRESS_LOW, 8'h0E);
        chk(32'(read_busy), 32'h0);
        wr(OFFSET_INDIRECT_DATA_BYTE0, 8'hFF);
        rd(OFFSET_INDIRECT_DATA_BYTE0, b);
        chk(32'(b), 32'hCD);
        rd(8'h90, b);
        chk(32'(b), 32'(UNMAPPED_READ_VALUE));
        tally_and_finish();
    end
endmodule : tb_top
